// ### verilog/pcs_defs.svh
/*
  Constants for the package idle-state controller: request codes, latency
  figures in nanoseconds and memory power-down timing in ref_clk cycles.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

`define PCS_NUM_CORES 4
`define PCS_CREQ_W 3
`define PCS_TOL_W 10
`define PCS_WAYS_W 5

// Raw core request codes
`define PCS_CREQ_ACTIVE 3'h0
`define PCS_CREQ_HALT 3'h1
`define PCS_CREQ_HALT_LOWFREQ 3'h2
`define PCS_CREQ_SLEEP_FLUSHED 3'h3
`define PCS_CREQ_POWER_GATED 3'h6
`define PCS_CREQ_SEVENTH 3'h7

// Exit latency figures, ns
`define PCS_LIGHT_ENTRY_NS 10'h028
`define PCS_DEEP_ENTRY_NS 10'h064
`define PCS_PLL_RELOCK_NS 10'h0c8
`define PCS_RET_RAMP_NS 10'h050
`define PCS_RET_SHALLOW_NS 10'h03c
`define PCS_RET_DEEP_NS 10'h12c

// Open last-level cache ways allowed for deep retention
`define PCS_LLC_WAYS_MAX 5'h04

// Memory power-down timing
`define PCS_MEM_EXIT_CYC 3'h4
`define PCS_MEM_IDLE_CYC 5'h10

`endif

// ### verilog/pcs_pkg.sv
/*
  Types shared by the package idle-state controller and its helpers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package pcs_pkg;
  typedef enum logic [2:0] {
    CORE_ACTIVE, CORE_HALT, CORE_HALT_LOWFREQ, CORE_SLEEP_FLUSHED, CORE_POWER_GATED
  } pcs_core_t;

  typedef enum logic [1:0] {
    PACKAGE_ACTIVE, PACKAGE_SNOOPABLE_IDLE, PACKAGE_LIGHT_RETENTION, PACKAGE_DEEP_RETENTION
  } pcs_pkgst_t;

  typedef enum logic [1:0] {
    VOLT_NORMAL, VOLT_MINIMUM_OPERATING, VOLT_RETENTION
  } pcs_volt_t;

  typedef enum logic {
    FREQ_REQUESTED, FREQ_LOWEST_POINT
  } pcs_freq_t;

  typedef enum logic [2:0] {
    SYS_FULL_ON, SYS_SUSPEND_RAM, SYS_SUSPEND_DISK, SYS_SOFT_OFF, SYS_MECH_OFF
  } pcs_sys_t;

  typedef enum logic [1:0] {
    MEM_ON, MEM_POWERDOWN, MEM_EXIT, MEM_SELF_REFRESH
  } pcs_mem_t;
endpackage

`default_nettype wire

// ### verilog/pcs_core_decode.sv
/*
  One core's idle request decoder: turns a raw request code into the core
  state and its clock, PLL, cache and power actions, all registered.
  Assumes the request is synchronous to ref_clk.
*/
`default_nettype none
`include "pcs_defs.svh"

module pcs_core_decode (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [`PCS_CREQ_W-1:0] req,
  output pcs_pkg::pcs_core_t coreState,
  output logic clkRun,
  output logic pllOn,
  output logic lowFreqReq,
  output logic flushToLlc,
  output logic retReq,
  output logic powerGate
);
  import pcs_pkg::*;

  pcs_core_t next_coreState;

  // Seventh level folds onto power gated
  always_comb begin
    unique case (req)
      `PCS_CREQ_ACTIVE: next_coreState = CORE_ACTIVE;
      `PCS_CREQ_HALT: next_coreState = CORE_HALT;
      `PCS_CREQ_HALT_LOWFREQ: next_coreState = CORE_HALT_LOWFREQ;
      `PCS_CREQ_SLEEP_FLUSHED: next_coreState = CORE_SLEEP_FLUSHED;
      `PCS_CREQ_POWER_GATED, `PCS_CREQ_SEVENTH: next_coreState = CORE_POWER_GATED;
      // Unused codes keep the core running rather than guess a depth
      default: next_coreState = CORE_ACTIVE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      coreState <= CORE_ACTIVE;
    end else begin
      coreState <= next_coreState;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clkRun <= 1'b1;
      pllOn <= 1'b1;
      lowFreqReq <= 1'b0;
      flushToLlc <= 1'b0;
      retReq <= 1'b0;
      powerGate <= 1'b0;
    end else begin
      clkRun <= (next_coreState == CORE_ACTIVE);
      pllOn <= (next_coreState != CORE_POWER_GATED);
      lowFreqReq <= (next_coreState == CORE_HALT_LOWFREQ);
      flushToLlc <= (next_coreState == CORE_SLEEP_FLUSHED) ||
                    (next_coreState == CORE_POWER_GATED);
      retReq <= (next_coreState == CORE_SLEEP_FLUSHED);
      powerGate <= (next_coreState == CORE_POWER_GATED);
    end
  end

  property p_seventh_maps;
    @(posedge ref_clk) disable iff (!nrst)
    (req == `PCS_CREQ_SEVENTH) |=> (coreState == CORE_POWER_GATED) && powerGate && !pllOn;
  endproperty
  a_seventh_maps: assert property (p_seventh_maps)
    else $error("seventh-level request not mapped to power gated");

  property p_halt_actions;
    @(posedge ref_clk) disable iff (!nrst)
    (coreState == CORE_HALT) |-> !clkRun && pllOn && !flushToLlc && !powerGate;
  endproperty
  a_halt_actions: assert property (p_halt_actions)
    else $error("halted core actions wrong");

  property p_flush_actions;
    @(posedge ref_clk) disable iff (!nrst)
    (coreState == CORE_SLEEP_FLUSHED) |-> flushToLlc && retReq && pllOn && !clkRun;
  endproperty
  a_flush_actions: assert property (p_flush_actions)
    else $error("flushed core actions wrong");
endmodule

`default_nettype wire

// ### verilog/pcs_mem_power.sv
/*
  Memory power control: hardware clock-enable power-down after idle time,
  timed exit, and self-refresh entered only on a software or system request.
  Assumes the busy and request inputs are synchronous to ref_clk.
*/
`default_nettype none
`include "pcs_defs.svh"

module pcs_mem_power (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic memBusy,
  input wire logic swSelfRefreshReq,
  input wire logic forceSelfRefresh,
  output pcs_pkg::pcs_mem_t memState,
  output logic memCke,
  output logic memCmdReady
);
  import pcs_pkg::*;

  pcs_mem_t next_memState;
  logic [4:0] idleCnt;
  logic [2:0] exitCnt;
  logic srReq;

  assign srReq = swSelfRefreshReq || forceSelfRefresh;
  assign memCmdReady = (memState == MEM_ON);

  always_comb begin
    next_memState = memState;
    unique case (memState)
      MEM_ON: begin
        if (srReq) begin
          next_memState = MEM_SELF_REFRESH;
        end else if (!memBusy && idleCnt == `PCS_MEM_IDLE_CYC - 5'h01) begin
          next_memState = MEM_POWERDOWN;
        end
      end
      MEM_POWERDOWN: begin
        if (srReq) begin
          next_memState = MEM_SELF_REFRESH;
        end else if (memBusy) begin
          next_memState = MEM_EXIT;
        end
      end
      MEM_EXIT: begin
        if (exitCnt == `PCS_MEM_EXIT_CYC - 3'h1) begin
          next_memState = MEM_ON;
        end
      end
      MEM_SELF_REFRESH: begin
        if (!srReq) begin
          next_memState = MEM_EXIT;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      memState <= MEM_ON;
    end else begin
      memState <= next_memState;
    end
  end

  // Clock enable low in power-down and self-refresh
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      memCke <= 1'b1;
    end else begin
      memCke <= (next_memState == MEM_ON) || (next_memState == MEM_EXIT);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      idleCnt <= 5'h00;
    end else if (memState != MEM_ON || memBusy) begin
      idleCnt <= 5'h00;
    end else if (idleCnt != `PCS_MEM_IDLE_CYC - 5'h01) begin
      idleCnt <= idleCnt + 5'h01;
    end
  end

  // Exit takes a fixed count within the window
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      exitCnt <= 3'h0;
    end else if (memState == MEM_EXIT) begin
      exitCnt <= exitCnt + 3'h1;
    end else begin
      exitCnt <= 3'h0;
    end
  end

  property p_exit_time;
    @(posedge ref_clk) disable iff (!nrst)
    $rose(memCke) |-> (!memCmdReady)[*4] ##1 memCmdReady;
  endproperty
  a_exit_time: assert property (p_exit_time)
    else $error("memory power-down exit not four cycles");

  property p_sr_by_request;
    @(posedge ref_clk) disable iff (!nrst)
    (memState != MEM_SELF_REFRESH) ##1 (memState == MEM_SELF_REFRESH) |-> $past(srReq);
  endproperty
  a_sr_by_request: assert property (p_sr_by_request)
    else $error("self-refresh entered without request");

  property p_idle_powerdown;
    @(posedge ref_clk) disable iff (!nrst)
    (memState == MEM_ON && !memBusy && !srReq)[*8] ##1 (!memBusy && !srReq)[*8] ##1
      (!memBusy && !srReq) |=> !memCke;
  endproperty
  a_idle_powerdown: assert property (p_idle_powerdown)
    else $error("idle memory not powered down");
endmodule

`default_nettype wire

// ### verilog/pcs_idle_ctrl.sv
/*
  Package idle-state controller: decodes every core's idle request, picks
  the deepest package state that no limit forbids, and drives the package
  PLL, voltage and frequency requests, system sleep outputs and memory
  clock-enable control.
  Assumes all inputs are synchronous to ref_clk and that tolerances are
  reported in nanoseconds by the platform and operating system.
*/
// Behaviour
// - Package state needs all cores deep enough
// - Snoops, sidebands and constraints hold snoopable idle
// - Response times and open ways limit retention
// - Resume always at lowest frequency point
// - Seventh level unsupported, mapped to gated
// - Retention actions chosen from exit latency
// - Retention voltage; snoopable keeps PLL, minimum voltage
// - Core retention voltage from response times
// - Per-core clock, PLL, flush, gating actions
// - Support system sleep states; RAM keeps context
// - Memory powers down by demand, no software
// - Hardware power-down; software starts self-refresh
// - Active power-down default, timed exit
`default_nettype none
`include "pcs_defs.svh"

module pcs_idle_ctrl (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [`PCS_NUM_CORES*`PCS_CREQ_W-1:0] coreReq,
  input wire logic ioSnoopPending,
  input wire logic remoteSnoopPending,
  input wire logic ioAccessPending,
  input wire logic remoteAccessPending,
  input wire logic intrRespUrgent,
  input wire logic sidebandBusy,
  input wire logic cfgConstraint,
  input wire logic [`PCS_TOL_W-1:0] snoopTolNs,
  input wire logic [`PCS_TOL_W-1:0] nonSnoopTolNs,
  input wire logic [`PCS_TOL_W-1:0] intrTolNs,
  input wire logic [`PCS_WAYS_W-1:0] llcWaysOpen,
  input wire logic perfReqValid,
  input wire pcs_pkg::pcs_sys_t sysState,
  input wire logic memBusy,
  input wire logic swSelfRefreshReq,
  output pcs_pkg::pcs_pkgst_t pkgState,
  output pcs_pkg::pcs_volt_t voltReq,
  output logic pllOn,
  output pcs_pkg::pcs_freq_t freqSel,
  output logic [1:0] coreRetLevel,
  output logic llcKeep,
  output logic [`PCS_NUM_CORES-1:0] coreClkRun,
  output logic [`PCS_NUM_CORES-1:0] corePllOn,
  output logic [`PCS_NUM_CORES-1:0] coreLowFreqReq,
  output logic [`PCS_NUM_CORES-1:0] coreFlushToLlc,
  output logic [`PCS_NUM_CORES-1:0] coreRetReq,
  output logic [`PCS_NUM_CORES-1:0] corePowerGate,
  output logic restPowerOff,
  output logic memCke,
  output logic memSelfRefresh,
  output logic memCmdReady
);
  import pcs_pkg::*;

  localparam int NC = `PCS_NUM_CORES;

  pcs_core_t coreState [NC];
  logic [NC-1:0] coreDeep;
  logic [NC-1:0] coreGated;
  logic [NC-1:0] coreFlushed;
  logic limitBlock;
  logic lightOk;
  logic deepOk;
  logic [`PCS_TOL_W-1:0] minTol;
  logic [`PCS_TOL_W-1:0] srTol;
  pcs_pkgst_t next_pkgState;
  logic memForceSr;
  pcs_mem_t memState;

  function automatic logic [`PCS_TOL_W-1:0] minOf(
    input logic [`PCS_TOL_W-1:0] a,
    input logic [`PCS_TOL_W-1:0] b
  );
    minOf = (a < b) ? a : b;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++) begin : g_core
      pcs_core_decode u_dec (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .req(coreReq[gi*`PCS_CREQ_W +: `PCS_CREQ_W]),
        .coreState(coreState[gi]),
        .clkRun(coreClkRun[gi]),
        .pllOn(corePllOn[gi]),
        .lowFreqReq(coreLowFreqReq[gi]),
        .flushToLlc(coreFlushToLlc[gi]),
        .retReq(coreRetReq[gi]),
        .powerGate(corePowerGate[gi])
      );
      assign coreGated[gi] = (coreState[gi] == CORE_POWER_GATED);
      assign coreFlushed[gi] = (coreState[gi] == CORE_SLEEP_FLUSHED);
      assign coreDeep[gi] = coreGated[gi] || coreFlushed[gi];
    end
  endgenerate

  assign minTol = minOf(minOf(snoopTolNs, nonSnoopTolNs), intrTolNs);
  assign srTol = minOf(snoopTolNs, intrTolNs);

  // Pending traffic, urgent interrupts, sideband and config constraints cap the package at snoopable idle
  assign limitBlock = ioSnoopPending || remoteSnoopPending || ioAccessPending ||
                      remoteAccessPending || intrRespUrgent || sidebandBusy ||
                      cfgConstraint;

  // Core depth gates; response times and open ways
  assign lightOk = (&coreDeep) && (|coreFlushed) && !limitBlock &&
                   (minTol >= `PCS_LIGHT_ENTRY_NS);
  assign deepOk = (&coreGated) && !limitBlock && (minTol >= `PCS_DEEP_ENTRY_NS) &&
                  (llcWaysOpen <= `PCS_LLC_WAYS_MAX);

  // Deepest allowed state, re-picked every cycle
  always_comb begin
    if (deepOk) begin
      next_pkgState = PACKAGE_DEEP_RETENTION;
    end else if (lightOk) begin
      next_pkgState = PACKAGE_LIGHT_RETENTION;
    end else if (&coreDeep) begin
      next_pkgState = PACKAGE_SNOOPABLE_IDLE;
    end else begin
      next_pkgState = PACKAGE_ACTIVE;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pkgState <= PACKAGE_ACTIVE;
    end else begin
      pkgState <= next_pkgState;
    end
  end

  // Retention actions follow the latency budget; defaults
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pllOn <= 1'b1;
      voltReq <= VOLT_NORMAL;
    end else begin
      unique case (next_pkgState)
        PACKAGE_ACTIVE: begin
          pllOn <= 1'b1;
          voltReq <= VOLT_NORMAL;
        end
        PACKAGE_SNOOPABLE_IDLE: begin
          pllOn <= 1'b1;
          voltReq <= VOLT_MINIMUM_OPERATING;
        end
        PACKAGE_LIGHT_RETENTION, PACKAGE_DEEP_RETENTION: begin
          pllOn <= (minTol < `PCS_PLL_RELOCK_NS);
          voltReq <= (minTol >= `PCS_RET_RAMP_NS) ? VOLT_RETENTION : VOLT_MINIMUM_OPERATING;
        end
      endcase
    end
  end

  // Idle and resume run at the lowest point until a new request
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      freqSel <= FREQ_REQUESTED;
    end else if (next_pkgState != PACKAGE_ACTIVE || pkgState != PACKAGE_ACTIVE) begin
      freqSel <= FREQ_LOWEST_POINT;
    end else if (perfReqValid) begin
      freqSel <= FREQ_REQUESTED;
    end
  end

  // Depth below minimum voltage tracks snoop and interrupt budget
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      coreRetLevel <= 2'h0;
    end else if (srTol >= `PCS_RET_DEEP_NS) begin
      coreRetLevel <= 2'h2;
    end else if (srTol >= `PCS_RET_SHALLOW_NS) begin
      coreRetLevel <= 2'h1;
    end else begin
      coreRetLevel <= 2'h0;
    end
  end

  // No package state flushes the shared cache
  assign llcKeep = 1'b1;

  // Sleep states drop the rest; RAM suspend holds memory in self-refresh
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      restPowerOff <= 1'b0;
      memForceSr <= 1'b0;
    end else begin
      restPowerOff <= (sysState != SYS_FULL_ON);
      memForceSr <= (sysState == SYS_SUSPEND_RAM);
    end
  end

  // Power-down is automatic; self-refresh needs a request
  pcs_mem_power u_mem (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .memBusy(memBusy),
    .swSelfRefreshReq(swSelfRefreshReq),
    .forceSelfRefresh(memForceSr),
    .memState(memState),
    .memCke(memCke),
    .memCmdReady(memCmdReady)
  );

  assign memSelfRefresh = (memState == MEM_SELF_REFRESH);

  property p_light_cores;
    @(posedge ref_clk) disable iff (!nrst)
    (pkgState == PACKAGE_LIGHT_RETENTION) |-> $past(&coreDeep) && $past(|coreFlushed);
  endproperty
  a_light_cores: assert property (p_light_cores)
    else $error("light retention without cores deep enough");

  property p_limit_holds;
    @(posedge ref_clk) disable iff (!nrst)
    limitBlock |=> (pkgState == PACKAGE_ACTIVE) || (pkgState == PACKAGE_SNOOPABLE_IDLE);
  endproperty
  a_limit_holds: assert property (p_limit_holds)
    else $error("package went deeper despite a pending limit");

  property p_deep_ways;
    @(posedge ref_clk) disable iff (!nrst)
    (llcWaysOpen > `PCS_LLC_WAYS_MAX) |=> (pkgState != PACKAGE_DEEP_RETENTION);
  endproperty
  a_deep_ways: assert property (p_deep_ways)
    else $error("deep retention with too many open ways");

  property p_resume_low;
    @(posedge ref_clk) disable iff (!nrst)
    (pkgState != PACKAGE_ACTIVE) ##1 (pkgState == PACKAGE_ACTIVE) |->
      (freqSel == FREQ_LOWEST_POINT) ##1 (freqSel == FREQ_LOWEST_POINT);
  endproperty
  a_resume_low: assert property (p_resume_low)
    else $error("resume not at lowest frequency point");

  property p_snoop_actions;
    @(posedge ref_clk) disable iff (!nrst)
    (pkgState == PACKAGE_SNOOPABLE_IDLE) |-> pllOn && (voltReq == VOLT_MINIMUM_OPERATING);
  endproperty
  a_snoop_actions: assert property (p_snoop_actions)
    else $error("snoopable idle actions wrong");

  property p_ret_dynamic;
    @(posedge ref_clk) disable iff (!nrst)
    (next_pkgState == PACKAGE_DEEP_RETENTION && minTol < `PCS_PLL_RELOCK_NS) |=> pllOn;
  endproperty
  a_ret_dynamic: assert property (p_ret_dynamic)
    else $error("PLL shut down beyond latency budget");

  property p_deepest;
    @(posedge ref_clk) disable iff (!nrst)
    deepOk |=> (pkgState == PACKAGE_DEEP_RETENTION);
  endproperty
  a_deepest: assert property (p_deepest)
    else $error("deepest allowed state not taken");

  property p_llc_kept;
    @(posedge ref_clk) disable iff (!nrst)
    (pkgState != PACKAGE_ACTIVE) |-> llcKeep;
  endproperty
  a_llc_kept: assert property (p_llc_kept)
    else $error("shared cache released in package idle");

  property p_ram_suspend;
    @(posedge ref_clk) disable iff (!nrst)
    (sysState == SYS_SUSPEND_RAM)[*3] |=> memSelfRefresh && restPowerOff;
  endproperty
  a_ram_suspend: assert property (p_ram_suspend)
    else $error("RAM suspend without memory self-refresh");

  property p_ret_level;
    @(posedge ref_clk) disable iff (!nrst)
    (srTol < `PCS_RET_SHALLOW_NS) |=> (coreRetLevel == 2'h0);
  endproperty
  a_ret_level: assert property (p_ret_level)
    else $error("core retention level too deep for budget");
endmodule

`default_nettype wire

// ### tb/pcs_platform_model.sv
/*
  Platform-side model: cores, platform agents, software and system control
  feeding the idle-state controller. Assumes tb_top calls its tasks.
*/
`default_nettype none
`include "pcs_defs.svh"

module pcs_platform_model (
  input wire logic ref_clk,
  output logic [`PCS_NUM_CORES*`PCS_CREQ_W-1:0] coreReq,
  output logic ioSnoopPending,
  output logic remoteSnoopPending,
  output logic ioAccessPending,
  output logic remoteAccessPending,
  output logic intrRespUrgent,
  output logic sidebandBusy,
  output logic cfgConstraint,
  output logic [`PCS_TOL_W-1:0] snoopTolNs,
  output logic [`PCS_TOL_W-1:0] nonSnoopTolNs,
  output logic [`PCS_TOL_W-1:0] intrTolNs,
  output logic [`PCS_WAYS_W-1:0] llcWaysOpen,
  output logic perfReqValid,
  output pcs_pkg::pcs_sys_t sysState,
  output logic memBusy,
  output logic swSelfRefreshReq
);
  timeunit 1ns;
  timeprecision 100ps;
  import pcs_pkg::*;

  // Memory starts busy so power-down stays out of the core tests
  initial begin
    coreReq = 12'h000;
    {cfgConstraint, sidebandBusy, intrRespUrgent, remoteAccessPending, ioAccessPending,
      remoteSnoopPending, ioSnoopPending} = 7'h00;
    snoopTolNs = 10'h12c;
    nonSnoopTolNs = 10'h12c;
    intrTolNs = 10'h12c;
    llcWaysOpen = 5'h00;
    perfReqValid = 1'b0;
    sysState = SYS_FULL_ON;
    memBusy = 1'b1;
    swSelfRefreshReq = 1'b0;
  end

  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic setCores(input logic [11:0] v);
    step;
    coreReq = v;
  endtask

  task automatic setLim(input logic [6:0] v);
    step;
    {cfgConstraint, sidebandBusy, intrRespUrgent, remoteAccessPending, ioAccessPending,
      remoteSnoopPending, ioSnoopPending} = v;
  endtask

  task automatic setTol(input logic [9:0] s, input logic [9:0] n, input logic [9:0] i);
    step;
    snoopTolNs = s;
    nonSnoopTolNs = n;
    intrTolNs = i;
  endtask

  task automatic setWays(input logic [4:0] v);
    step;
    llcWaysOpen = v;
  endtask

  task automatic setPerf(input logic v);
    step;
    perfReqValid = v;
  endtask

  task automatic setSys(input pcs_sys_t v);
    step;
    sysState = v;
  endtask

  task automatic setMem(input logic busy, input logic sr);
    step;
    memBusy = busy;
    swSelfRefreshReq = sr;
  endtask
endmodule

`default_nettype wire

// ### tb/tb_top.sv
/*
  Scenario bench for the package idle-state controller.
  Assumes the design files and the platform model are compiled first.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pcs_pkg::*;

  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] coreReq;
  logic ioSnoopPending, remoteSnoopPending, ioAccessPending, remoteAccessPending;
  logic intrRespUrgent, sidebandBusy, cfgConstraint;
  logic [9:0] snoopTolNs, nonSnoopTolNs, intrTolNs;
  logic [4:0] llcWaysOpen;
  logic perfReqValid, memBusy, swSelfRefreshReq;
  pcs_sys_t sysState;
  pcs_pkgst_t pkgState;
  pcs_volt_t voltReq;
  pcs_freq_t freqSel;
  logic pllOn, llcKeep, restPowerOff, memCke, memSelfRefresh, memCmdReady;
  logic [1:0] coreRetLevel;
  logic [3:0] coreClkRun, corePllOn, coreLowFreqReq, coreFlushToLlc, coreRetReq, corePowerGate;
  int n_errors = 0;
  int compares = 0;

  always #5 ref_clk = ~ref_clk;

  pcs_platform_model pcs_platform_model_i (.ref_clk, .coreReq, .ioSnoopPending,
    .remoteSnoopPending, .ioAccessPending, .remoteAccessPending, .intrRespUrgent,
    .sidebandBusy, .cfgConstraint, .snoopTolNs, .nonSnoopTolNs, .intrTolNs, .llcWaysOpen,
    .perfReqValid, .sysState, .memBusy, .swSelfRefreshReq);

  pcs_idle_ctrl pcs_idle_ctrl_i (.ref_clk, .nrst, .coreReq, .ioSnoopPending,
    .remoteSnoopPending, .ioAccessPending, .remoteAccessPending, .intrRespUrgent,
    .sidebandBusy, .cfgConstraint, .snoopTolNs,
    .nonSnoopTolNs, .intrTolNs, .llcWaysOpen, .perfReqValid, .sysState, .memBusy,
    .swSelfRefreshReq, .pkgState, .voltReq, .pllOn, .freqSel, .coreRetLevel, .llcKeep,
    .coreClkRun, .corePllOn, .coreLowFreqReq, .coreFlushToLlc, .coreRetReq,
    .corePowerGate, .restPowerOff, .memCke, .memSelfRefresh, .memCmdReady);

  task automatic summarize;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    n_errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic chkVec(input logic [3:0] got, input logic [3:0] exp, input string m);
    compares++;
    if (got !== exp) fail(m);
  endtask

  task automatic chkBit(input logic got, input logic exp, input string m);
    compares++;
    if (got !== exp) fail(m);
  endtask

  task automatic chkPkg(input pcs_pkgst_t got, input pcs_pkgst_t exp, input string m);
    compares++;
    if (got !== exp) fail(m);
  endtask

  task automatic chkVolt(input pcs_volt_t got, input pcs_volt_t exp, input string m);
    compares++;
    if (got !== exp) fail(m);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_reset;
    chkPkg(pkgState, PACKAGE_ACTIVE, "reset pkg");
    chkVolt(voltReq, VOLT_NORMAL, "reset volt");
    chkBit(freqSel, 1'b0, "reset freq");
    chkVec({pllOn, memCke, memCmdReady, restPowerOff}, 4'he, "reset pll mem");
    chkVec(coreClkRun & corePllOn, 4'hf, "reset core clocks");
    chkBit(llcKeep, 1'b1, "cache kept");
  endtask

  task automatic t_deep;
    pcs_platform_model_i.setCores(12'hdb6);
    pcs_platform_model_i.setTol(10'h064, 10'h064, 10'h064);
    settle(3);
    chkPkg(pkgState, PACKAGE_DEEP_RETENTION, "deep");
    chkVec(coreClkRun, 4'h0, "gated clocks");
    chkVec(corePllOn, 4'h0, "gated plls");
    chkVec(corePowerGate, 4'hf, "gated");
    chkBit(freqSel, 1'b1, "idle freq");
    chkVolt(voltReq, VOLT_RETENTION, "deep volt");
    chkBit(pllOn, 1'b1, "short latency keeps pll");
    pcs_platform_model_i.setTol(10'h0fa, 10'h0fa, 10'h0fa);
    settle(2);
    chkBit(pllOn, 1'b0, "long latency pll off");
    pcs_platform_model_i.setWays(5'h05);
    settle(2);
    chkPkg(pkgState, PACKAGE_SNOOPABLE_IDLE, "ways block deep");
    chkVolt(voltReq, VOLT_MINIMUM_OPERATING, "snoopable volt");
    chkBit(pllOn, 1'b1, "snoopable pll");
    pcs_platform_model_i.setWays(5'h04);
    pcs_platform_model_i.setTol(10'h063, 10'h12c, 10'h12c);
    settle(2);
    chkPkg(pkgState, PACKAGE_SNOOPABLE_IDLE, "latency blocks deep");
  endtask

  task automatic t_light;
    pcs_platform_model_i.setCores(12'hdb3);
    pcs_platform_model_i.setTol(10'h12c, 10'h028, 10'h12c);
    settle(3);
    chkPkg(pkgState, PACKAGE_LIGHT_RETENTION, "light");
    chkVec(coreFlushToLlc, 4'hf, "flushed");
    chkVec(corePowerGate, 4'he, "one core not gated");
    chkVec(coreRetReq, 4'h1, "flushed core retention");
    chkVolt(voltReq, VOLT_MINIMUM_OPERATING, "short budget volt");
    pcs_platform_model_i.setTol(10'h12c, 10'h027, 10'h12c);
    settle(2);
    chkPkg(pkgState, PACKAGE_SNOOPABLE_IDLE, "light latency");
  endtask

  task automatic t_limits;
    pcs_platform_model_i.setCores(12'hfff);
    pcs_platform_model_i.setTol(10'h12c, 10'h12c, 10'h12c);
    settle(3);
    chkPkg(pkgState, PACKAGE_DEEP_RETENTION, "seventh mapped");
    chkVec(corePowerGate, 4'hf, "seventh gated");
    for (int i = 0; i < 7; i++) begin
      pcs_platform_model_i.setLim(7'(1 << i));
      settle(2);
      chkPkg(pkgState, PACKAGE_SNOOPABLE_IDLE, "limit holds snoopable");
    end
    pcs_platform_model_i.setLim(7'h00);
    settle(2);
    chkPkg(pkgState, PACKAGE_DEEP_RETENTION, "limit cleared");
  endtask

  task automatic t_resume;
    pcs_platform_model_i.setCores(12'h888);
    settle(3);
    chkPkg(pkgState, PACKAGE_ACTIVE, "resume");
    chkBit(freqSel, 1'b1, "resume lowest point");
    chkVolt(voltReq, VOLT_NORMAL, "resume volt");
    chkVec(coreClkRun, 4'h9, "halted clocks");
    chkVec(coreLowFreqReq, 4'h4, "halt low freq");
    pcs_platform_model_i.setPerf(1'b1);
    settle(2);
    chkBit(freqSel, 1'b0, "requested freq");
    pcs_platform_model_i.setPerf(1'b0);
  endtask

  task automatic t_retlvl;
    logic [9:0] s[4] = '{10'h12c, 10'h12b, 10'h12c, 10'h03c};
    logic [9:0] i[4] = '{10'h12c, 10'h12c, 10'h03c, 10'h03b};
    logic [3:0] e[4] = '{4'h2, 4'h1, 4'h1, 4'h0};
    for (int k = 0; k < 4; k++) begin
      pcs_platform_model_i.setTol(s[k], 10'h3ff, i[k]);
      settle(2);
      chkVec({2'h0, coreRetLevel}, e[k], "retention level");
    end
  endtask

  task automatic t_mem;
    int n = 0;
    pcs_platform_model_i.setMem(1'b0, 1'b0);
    while (memCke !== 1'b0 && n < 30) begin
      settle(1);
      n++;
    end
    chkBit(n == 16, 1'b1, "idle power-down");
    pcs_platform_model_i.setMem(1'b1, 1'b0);
    settle(1);
    chkBit(memCke, 1'b1, "exit cke");
    n = 0;
    while (memCmdReady !== 1'b1 && n < 10) begin
      n++;
      settle(1);
    end
    chkVec(4'(n), 4'h4, "exit time");
  endtask

  task automatic t_selfref;
    pcs_platform_model_i.setMem(1'b1, 1'b1);
    settle(1);
    chkVec({2'h0, memCke, memSelfRefresh}, 4'h1, "self-refresh");
    pcs_platform_model_i.setMem(1'b1, 1'b0);
    settle(1);
    chkBit(memCke, 1'b1, "self-refresh exit");
    settle(6);
    pcs_platform_model_i.setSys(SYS_SUSPEND_RAM);
    settle(2);
    chkVec({2'h0, restPowerOff, memSelfRefresh}, 4'h3, "suspend to ram");
    pcs_platform_model_i.setSys(SYS_FULL_ON);
    settle(8);
    chkBit(restPowerOff, 1'b0, "full on");
    // Disk suspend, soft off and mechanical off drop the rest, memory untouched
    for (int k = 2; k < 5; k++) begin
      pcs_platform_model_i.setSys(pcs_sys_t'(k));
      settle(1);
      chkBit(restPowerOff, 1'b1, "sleep powers rest off");
      chkBit(memSelfRefresh, 1'b0, "no forced self-refresh");
    end
  endtask

  initial begin
    settle(2);
    t_reset;
    nrst = 1'b1;
    t_deep;
    t_light;
    t_limits;
    t_resume;
    t_retlvl;
    t_mem;
    t_selfref;
    summarize;
  end
endmodule

`default_nettype wire
